// ### core/split_timer_defines.svh
// Purpose: register map and field positions of the split timer
// Assumes: 32-bit AHB-Lite data, one aligned word per register
// Notes: field ranges are written hi:lo for direct part-selects
`ifndef SPLIT_TIMER_DEFINES_SVH
`define SPLIT_TIMER_DEFINES_SVH
// register byte offsets, low address bits only
`define ADDR_BITS 7:0
`define OFF_CLK_DIV 8'h04
`define OFF_LOW_COUNT 8'h10
`define OFF_HIGH_COUNT 8'h14
`define OFF_LOW_PERIOD 8'h18
`define OFF_HIGH_PERIOD 8'h1C
`define OFF_TIMER_CTRL 8'h20
`define OFF_GLOBAL_CTRL 8'h24
`define OFF_WDOG_CTRL 8'h28
// timer control register fields
`define TC_STAT_LO 0
`define TC_INV_LO 2
`define TC_LOWER_CLOCK_PULSE_SELECT 3
`define TC_PW_LO 5:4
`define TC_EN_LO 7:6
`define TC_SRC_LO 8
`define TC_GATE_LO 9
`define TC_INVIN_LO 10
`define TC_STAT_HI 16
`define TC_INV_HI 18
`define TC_UPPER_CLOCK_PULSE_SELECT 19
`define TC_PW_HI 21:20
`define TC_EN_HI 23:22
`define TC_WMASK 32'h00FC07FC
// global control register fields
`define GC_RUN_LO 0
`define GC_RUN_HI 1
`define GC_CFG 3:2
`define GC_PSC 11:8
`define GC_DDR 15:12
`define GC_WMASK 32'h0000FF0F
// watchdog control register fields
`define WD_ARM 0
`define WD_WMASK 32'h00000001
// bus constants and reset values
`define HTRANS_BUSY_BIT 1
`define RESP_OKAY 1'h0
`define WORD_ZERO 32'h00000000
`define WORD_ONES 32'hFFFFFFFF
`define PSC_ZERO 4'h0
`define PSC_STEP 4'h1
`endif

// ### core/split_timer_pkg.sv
// Purpose: shared types of the split timer
// Assumes: used through scoped names only
// Notes: bus states are binary coded from idle
package split_timer_pkg;
   typedef enum logic [1:0] {
      CFG_WIDE = 2'h0,
      CFG_UNCHAINED = 2'h1,
      CFG_WATCHDOG = 2'h2,
      CFG_CHAINED = 2'h3
   } cfg_t;
   typedef enum logic [1:0] {
      EN_OFF = 2'h0,
      EN_ONCE = 2'h1,
      EN_CONT = 2'h2,
      EN_SPARE = 2'h3
   } enmode_t;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'h0,
      BUS_READ = 2'h1,
      BUS_WRITE = 2'h2
   } bus_state_t;
endpackage

// ### core/half_if.sv
// Purpose: control bundle between the timer core and one count half
// Assumes: one clock domain
// Notes: eq is combinational from count and period
`timescale 1ns/1ps
interface half_if #(parameter int W = 32);
   logic tick;
   logic clr;
   logic wr;
   logic [W-1:0] wdata;
   logic [W-1:0] period;
   logic [W-1:0] count;
   logic eq;
   modport ctrl(output tick, clr, wr, wdata, period, input count, eq);
   modport half(input tick, clr, wr, wdata, period, output count, eq);
endinterface

// ### core/count_half.sv
// Purpose: one 32-bit count word with period compare
// Assumes: tick, clr and wr are single-cycle qualifiers
// Notes: software load beats clear, clear beats advance
`timescale 1ns/1ps
module count_half (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // control bundle
   half_if.half hb
);
   // compare against the period
   assign hb.eq = (hb.count == hb.period);

   // load, clear or advance the count
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hb.count <= '0;
      end else if (ce) begin
         if (hb.wr) begin
            hb.count <= hb.wdata;
         end else if (hb.clr) begin
            hb.count <= '0;
         end else if (hb.tick) begin
            hb.count <= hb.count + 1'h1;
         end
      end
   end
endmodule // count_half

// ### core/out_shaper.sv
// Purpose: pulse or clock mode output shaping for one half
// Assumes: fire is a one-cycle match pulse
// Notes: pulse length counts wtick edges, so its first tick may be partial
`timescale 1ns/1ps
module out_shaper (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // events and settings
   input wire logic fire,
   input wire logic wtick,
   input wire logic clkMode,
   input wire logic invert,
   input wire logic [1:0] width,
   // shaped level
   output logic level
);
   logic pulseQ;
   logic togQ;
   logic [1:0] widCntQ;

   // pulse stretch, toggle and registered output level
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pulseQ <= 1'h0;
         togQ <= 1'h0;
         widCntQ <= 2'h0;
         level <= 1'h0;
      end else if (ce) begin
         if (fire) begin
            pulseQ <= 1'h1;
            widCntQ <= 2'h0;
         end else if (pulseQ && wtick) begin
            if (widCntQ == width) begin
               pulseQ <= 1'h0;
            end else begin
               widCntQ <= widCntQ + 2'h1;
            end
         end
         if (fire) begin
            togQ <= ~togQ;
         end
         level <= (clkMode ? togQ : pulseQ) ^ invert;
      end
   end
endmodule // out_shaper

// ### core/split_timer_top.sv
// Purpose: configurable 64-bit or dual 32-bit general-purpose timer
// Assumes: AHB-Lite single word transfers, pins synchronous to clk
// Notes: reads take one wait state, writes none; hresp is always okay
`timescale 1ns/1ps
`include "split_timer_defines.svh"

module split_timer_top #(
   parameter int DIV_W = 8
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // board pins
   input wire logic timerInputPin,
   output logic timerOutputPin,
   // events
   output logic lowerInterrupt,
   output logic lowerDmaEvent,
   output logic upperInterrupt,
   output logic upperDmaEvent
);
   // true for the two counting enable modes
   function automatic logic isActive(input split_timer_pkg::enmode_t m);
      isActive = (m == split_timer_pkg::EN_ONCE) ||
                 (m == split_timer_pkg::EN_CONT);
   endfunction

   // bus state
   split_timer_pkg::bus_state_t busQ;
   logic [7:0] addrQ;
   logic hreadyQ;
   logic [31:0] rdataQ;
   // registers
   logic [31:0] tcrQ;
   logic [31:0] tcrD;
   logic [31:0] gcrQ;
   logic [31:0] gcrD;
   logic [31:0] wdcQ;
   logic [31:0] lowPeriodQ;
   logic [31:0] highPeriodQ;
   logic [DIV_W-1:0] divQ;
   logic [DIV_W-1:0] divCntQ;
   logic wdLockQ;
   // clocking and event state
   logic [2:0] pinSyncQ;
   logic preTickQ;
   logic pscFireQ;
   logic loEvtQ;
   logic hiEvtQ;
   logic loLevel;
   logic hiLevel;

   half_if #(.W(32)) lo();
   half_if #(.W(32)) hi();

   // address phase qualification
   wire take = hsel && hready && htrans[`HTRANS_BUSY_BIT];
   wire takeRd = take && !hwrite;
   wire takeWr = take && hwrite;
   wire wrPhase = (busQ == split_timer_pkg::BUS_WRITE);

   // write decode in the data phase
   wire wrDiv = wrPhase && (addrQ == `OFF_CLK_DIV);
   wire wrLowCnt = wrPhase && (addrQ == `OFF_LOW_COUNT);
   wire wrHighCnt = wrPhase && (addrQ == `OFF_HIGH_COUNT);
   wire wrLowPrd = wrPhase && (addrQ == `OFF_LOW_PERIOD);
   wire wrHighPrd = wrPhase && (addrQ == `OFF_HIGH_PERIOD);
   wire wrTcr = wrPhase && (addrQ == `OFF_TIMER_CTRL);
   wire wrGcr = wrPhase && (addrQ == `OFF_GLOBAL_CTRL);
   wire wrWdc = wrPhase && (addrQ == `OFF_WDOG_CTRL);

   // control field views
   wire split_timer_pkg::cfg_t cfg = split_timer_pkg::cfg_t'(gcrQ[`GC_CFG]);
   wire split_timer_pkg::enmode_t loMode =
      split_timer_pkg::enmode_t'(tcrQ[`TC_EN_LO]);
   wire split_timer_pkg::enmode_t hiMode =
      split_timer_pkg::enmode_t'(tcrQ[`TC_EN_HI]);
   wire runLo = gcrQ[`GC_RUN_LO];
   wire runHi = gcrQ[`GC_RUN_HI];
   wire isWide = (cfg == split_timer_pkg::CFG_WIDE);
   wire isUnch = (cfg == split_timer_pkg::CFG_UNCHAINED);
   wire isChain = (cfg == split_timer_pkg::CFG_CHAINED);
   wire loGo = runLo && isActive(loMode);
   wire hiGo = runHi && isActive(hiMode);

   // timer clock sources: divided internal, gated, or input pin edge
   wire intTick = (divCntQ == divQ);
   wire pinLvl = pinSyncQ[1] ^ tcrQ[`TC_INVIN_LO];
   wire pinPrev = pinSyncQ[2] ^ tcrQ[`TC_INVIN_LO];
   wire extRise = pinLvl && !pinPrev;
   wire gatedTick = tcrQ[`TC_GATE_LO] ? (intTick && pinLvl) : intTick;
   wire srcTick = tcrQ[`TC_SRC_LO] ? extRise : gatedTick;

   // lower half advance and match
   wire tickWide = srcTick && loGo && runHi;
   wire loTick = isWide ? tickWide :
                 isChain ? (preTickQ && loGo) :
                 isUnch ? (srcTick && loGo) : 1'h0;
   wire loMatch = isWide ? (lo.eq && hi.eq) : lo.eq;
   wire loWrap = loTick && loMatch;

   // upper half advance and match
   wire loAllOnes = (lo.count == `WORD_ONES);
   wire hiTick = isWide ? (tickWide && loAllOnes) :
                 isChain ? (srcTick && runLo && runHi) :
                 isUnch ? (pscFireQ && hiGo) : 1'h0;
   wire hiWrap = hiTick && hi.eq;
   wire hiEvt = isUnch && hiWrap;

   // unchained 4-bit prescaler on the internal clock only
   wire [3:0] pscNow = gcrQ[`GC_PSC];
   wire pscHit = (pscNow == gcrQ[`GC_DDR]);
   wire pscStep = isUnch && hiGo && intTick;

   // count half connections
   assign lo.tick = loTick;
   assign lo.clr = loWrap || !runLo;
   assign lo.wr = wrLowCnt;
   assign lo.wdata = hwdata;
   assign lo.period = lowPeriodQ;
   assign hi.tick = hiTick;
   assign hi.clr = (isWide ? loWrap : hiWrap) || !runHi;
   assign hi.wr = wrHighCnt;
   assign hi.wdata = hwdata;
   assign hi.period = highPeriodQ;

   count_half lowHalf (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .hb(lo)
   );

   count_half highHalf (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .hb(hi)
   );

   // lower output drives the pin and the lower status bit
   out_shaper lowShaper (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .fire(loWrap),
      .wtick(srcTick),
      .clkMode(tcrQ[`TC_LOWER_CLOCK_PULSE_SELECT]),
      .invert(tcrQ[`TC_INV_LO]),
      .width(tcrQ[`TC_PW_LO]),
      .level(loLevel)
   );

   // upper output only reaches the upper status bit
   out_shaper highShaper (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .fire(hiEvt),
      .wtick(intTick),
      .clkMode(tcrQ[`TC_UPPER_CLOCK_PULSE_SELECT]),
      .invert(tcrQ[`TC_INV_HI]),
      .width(tcrQ[`TC_PW_HI]),
      .level(hiLevel)
   );

   // timer control next value: write, then one-shot disarm
   always_comb begin
      tcrD = tcrQ;
      if (wrTcr) begin
         tcrD = (tcrQ & ~`TC_WMASK) | (hwdata & `TC_WMASK);
      end else begin
         if (loWrap && loMode == split_timer_pkg::EN_ONCE) begin
            tcrD[`TC_EN_LO] = split_timer_pkg::EN_OFF;
         end
         if (hiEvt && hiMode == split_timer_pkg::EN_ONCE) begin
            tcrD[`TC_EN_HI] = split_timer_pkg::EN_OFF;
         end
      end
   end

   // global control next value: locked configuration, prescale count
   always_comb begin
      gcrD = gcrQ;
      if (wrGcr) begin
         gcrD = (gcrQ & ~`GC_WMASK) | (hwdata & `GC_WMASK);
         if (wdLockQ || cfg == split_timer_pkg::CFG_WATCHDOG) begin
            gcrD[`GC_CFG] = gcrQ[`GC_CFG];
         end
      end else if (!runHi) begin
         gcrD[`GC_PSC] = `PSC_ZERO;
      end else if (pscStep) begin
         gcrD[`GC_PSC] = pscHit ? `PSC_ZERO : pscNow + `PSC_STEP;
      end
   end

   // read data selection
   wire [31:0] tcrRead = tcrQ | (32'(loLevel) << `TC_STAT_LO) |
                         (32'(hiLevel) << `TC_STAT_HI);
   wire [31:0] readMux =
      (addrQ == `OFF_CLK_DIV) ? 32'(divQ) :
      (addrQ == `OFF_LOW_COUNT) ? lo.count :
      (addrQ == `OFF_HIGH_COUNT) ? hi.count :
      (addrQ == `OFF_LOW_PERIOD) ? lowPeriodQ :
      (addrQ == `OFF_HIGH_PERIOD) ? highPeriodQ :
      (addrQ == `OFF_TIMER_CTRL) ? tcrRead :
      (addrQ == `OFF_GLOBAL_CTRL) ? gcrQ :
      (addrQ == `OFF_WDOG_CTRL) ? wdcQ : `WORD_ZERO;

   // bus slave: zero-wait writes, reads with one wait state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busQ <= split_timer_pkg::BUS_IDLE;
         addrQ <= 8'h00;
         hreadyQ <= 1'h1;
         rdataQ <= `WORD_ZERO;
      end else if (ce) begin
         case (busQ)
            split_timer_pkg::BUS_READ: begin
               rdataQ <= readMux;
               hreadyQ <= 1'h1;
               busQ <= split_timer_pkg::BUS_IDLE;
            end
            default: begin
               if (takeRd) begin
                  busQ <= split_timer_pkg::BUS_READ;
                  hreadyQ <= 1'h0;
                  addrQ <= haddr[`ADDR_BITS];
               end else if (takeWr) begin
                  busQ <= split_timer_pkg::BUS_WRITE;
                  addrQ <= haddr[`ADDR_BITS];
               end else begin
                  busQ <= split_timer_pkg::BUS_IDLE;
               end
            end
         endcase
      end
   end

   assign hreadyout = hreadyQ;
   assign hrdata = rdataQ;
   assign hresp = `RESP_OKAY;

   // control registers; reset values select the 64-bit counter
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tcrQ <= `WORD_ZERO;
         gcrQ <= `WORD_ZERO;
         wdcQ <= `WORD_ZERO;
         wdLockQ <= 1'h0;
      end else if (ce) begin
         tcrQ <= tcrD;
         gcrQ <= gcrD;
         if (wrWdc) begin
            wdcQ <= hwdata & `WD_WMASK;
         end
         if (cfg == split_timer_pkg::CFG_WATCHDOG) begin
            wdLockQ <= 1'h1;
         end
      end
   end

   // period words and internal clock divider setting
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lowPeriodQ <= `WORD_ZERO;
         highPeriodQ <= `WORD_ZERO;
         divQ <= '0;
      end else if (ce) begin
         if (wrLowPrd) begin
            lowPeriodQ <= hwdata;
         end
         if (wrHighPrd) begin
            highPeriodQ <= hwdata;
         end
         if (wrDiv) begin
            divQ <= hwdata[DIV_W-1:0];
         end
      end
   end

   // internal clock divider and input pin synchroniser
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         divCntQ <= '0;
         pinSyncQ <= 3'h0;
      end else if (ce) begin
         divCntQ <= (intTick || wrDiv) ? '0 : divCntQ + 1'h1; // no wrap stall
         pinSyncQ <= {pinSyncQ[1:0], timerInputPin};
      end
   end

   // prescaler ticks land one cycle after their match
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         preTickQ <= 1'h0;
         pscFireQ <= 1'h0;
      end else if (ce) begin
         preTickQ <= isChain && hiWrap;
         pscFireQ <= pscStep && pscHit;
      end
   end

   // registered event pulses
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         loEvtQ <= 1'h0;
         hiEvtQ <= 1'h0;
      end else if (ce) begin
         loEvtQ <= loWrap;
         hiEvtQ <= hiEvt;
      end
   end

   assign lowerInterrupt = loEvtQ;
   assign lowerDmaEvent = loEvtQ;
   assign upperInterrupt = hiEvtQ;
   assign upperDmaEvent = hiEvtQ;
   assign timerOutputPin = loLevel;
endmodule // split_timer_top

// ### testbench/split_timer_monitor.sv
// Purpose: port checks of the split timer bus and event outputs
// Assumes: hready is looped back from hreadyout
// Notes: bound onto the top module from the bench
`timescale 1ns/1ps
module split_timer_monitor (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   // events
   input wire logic lowerInterrupt,
   input wire logic lowerDmaEvent,
   input wire logic upperInterrupt,
   input wire logic upperDmaEvent
);
   // a transfer is taken on this edge
   wire logic take = hsel && hready && htrans[1] && ce;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // reads stall once, writes never
   a_read_wait: assert property (take && !hwrite |=> !hreadyout)
      else $error("read answered without a wait cycle");
   a_write_nowait: assert property (take && hwrite |=> hreadyout)
      else $error("write stalled the bus");
   a_wait_once: assert property (!hreadyout && ce |=> hreadyout)
      else $error("wait state longer than one cycle");
   a_wait_cause: assert property ($fell(hreadyout) |->
      $past(take && !hwrite))
      else $error("wait state without a read");
   // read data moves only when a read completes
   a_rdata_hold: assert property ($changed(hrdata) |->
      $rose(hreadyout))
      else $error("read data changed outside a read");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("error response seen");
   // interrupt and dma event travel together
   a_lower_pair: assert property (lowerInterrupt == lowerDmaEvent)
      else $error("lower interrupt and event differ");
   a_upper_pair: assert property (upperInterrupt == upperDmaEvent)
      else $error("upper interrupt and event differ");
endmodule // split_timer_monitor

// ### testbench/pin_partner.sv
// Purpose: board side source of the timer input pin
// Assumes: bench raises run only while the pin is used as a clock or as a gate
// Notes: pin rests low when stopped
`timescale 1ns/1ps
module pin_partner #(
   parameter int HALF = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   input wire logic run,
   // pin
   output logic pin
);
   int cnt;
   // square wave, HALF cycles per phase
   always @(posedge clk or posedge rst) begin
      if (rst || !run) begin
         cnt <= 0;
         pin <= 1'b0;
      end else if (cnt == HALF - 1) begin
         cnt <= 0;
         pin <= !pin;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule // pin_partner

// ### testbench/testbench.sv
// Purpose: self-checking bench of the split timer
// Assumes: ce high but for one freeze, divider 0 outside its own test
// Notes: intervals are counted in clk cycles between samples
`timescale 1ns/1ps
`include "split_timer_defines.svh"
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic pinRun = 1'b0;
   logic hreadyout, hresp, timerInputPin, timerOutputPin;
   logic lowerInterrupt, lowerDmaEvent, upperInterrupt, upperDmaEvent;
   logic [31:0] hrdata;
   int miscompares = 0;
   int totalChecks = 0;
   int cycles = 0;
   int n;
   always #5 clk = ~clk;
   split_timer_top dut (.clk, .rst, .ce, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
      .timerInputPin, .timerOutputPin, .lowerInterrupt, .lowerDmaEvent,
      .upperInterrupt, .upperDmaEvent);
   pin_partner #(.HALF(4)) partner (.clk, .rst, .run(pinRun),
      .pin(timerInputPin));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checks=%0d miscompares=%0d", totalChecks, miscompares);
      if (miscompares == 0 && totalChecks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // address phase, then data phase, each held until hready
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, q);
      check(q, e);
   endtask
   function automatic logic [31:0] timer_control_reg(input logic [1:0] en,
         input logic cp, input logic [1:0] pw, input logic inv,
         input logic src, input logic [1:0] enHi);
      logic [31:0] v;
      v = 32'h0;
      v[`TC_EN_LO] = en;
      v[`TC_LOWER_CLOCK_PULSE_SELECT] = cp;
      v[`TC_PW_LO] = pw;
      v[`TC_INV_LO] = inv;
      v[`TC_SRC_LO] = src;
      v[`TC_EN_HI] = enHi;
      return v;
   endfunction
   function automatic logic [31:0] gcr(input logic run,
         input logic [1:0] cfg, input logic [3:0] ddr);
      logic [31:0] v;
      v = 32'h0;
      v[`GC_RUN_LO] = run;
      v[`GC_RUN_HI] = run;
      v[`GC_CFG] = cfg;
      v[`GC_DDR] = ddr;
      return v;
   endfunction
   // counters held at zero while periods and modes are loaded
   task automatic setup(input logic [1:0] cfg, input logic [3:0] ddr,
         input logic [31:0] lp, input logic [31:0] hp, input logic [31:0] t);
      wr(`OFF_GLOBAL_CTRL, gcr(1'b0, cfg, ddr));
      wr(`OFF_LOW_PERIOD, lp);
      wr(`OFF_HIGH_PERIOD, hp);
      wr(`OFF_TIMER_CTRL, t);
      wr(`OFF_GLOBAL_CTRL, gcr(1'b1, cfg, ddr));
   endtask
   function automatic logic pick(input int which);
      case (which)
         0: return lowerInterrupt;
         1: return upperInterrupt;
         2: return timerOutputPin;
         default: return !timerOutputPin;
      endcase
   endfunction
   task automatic waitFor(input int which, input logic val);
      int k;
      k = 0;
      while (pick(which) !== val && k < 300) begin
         @(posedge clk);
         k++;
      end
   endtask
   // cycles from a rising sample until the signal reads want
   task automatic span(input int which, input logic want, output int c);
      waitFor(which, 1'b0);
      waitFor(which, 1'b1);
      c = 0;
      do begin
         @(posedge clk);
         c++;
      end while (pick(which) !== want && c < 300);
   endtask
   task automatic doReset();
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
   endtask
   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles > 20000) begin
         miscompares++;
         conclude();
      end
   end
   initial begin
      doReset();
      rdChk(`OFF_GLOBAL_CTRL, 32'h0);
      rdChk(`OFF_TIMER_CTRL, 32'h0);
      wr(8'h00, 32'hFFFFFFFF);
      rdChk(8'h00, 32'h0);
      wr(`OFF_GLOBAL_CTRL, 32'hFFFF00F3);
      rdChk(`OFF_GLOBAL_CTRL, 32'h00000003);
      wr(`OFF_LOW_COUNT, 32'h5);
      rdChk(`OFF_LOW_COUNT, 32'h5);
      wr(`OFF_GLOBAL_CTRL, 32'h0);
      wr(`OFF_LOW_COUNT, 32'h5);
      rdChk(`OFF_LOW_COUNT, 32'h0);
      // 64-bit one-shot across the word carry
      setup(split_timer_pkg::CFG_WIDE, 4'h0, 32'h1, 32'h1, 32'h0);
      wr(`OFF_LOW_COUNT, 32'hFFFFFFFE);
      wr(`OFF_HIGH_COUNT, 32'h0);
      wr(`OFF_TIMER_CTRL, timer_control_reg(split_timer_pkg::EN_ONCE, 0, 0, 0, 0, 0));
      waitFor(0, 1'b1);
      check({31'h0, pick(0)}, 32'h1);
      check({31'h0, lowerDmaEvent}, 32'h1);
      repeat (6) @(posedge clk);
      rdChk(`OFF_LOW_COUNT, 32'h0);
      rdChk(`OFF_HIGH_COUNT, 32'h0);
      rdChk(`OFF_TIMER_CTRL, 32'h0);
      setup(split_timer_pkg::CFG_WIDE, 4'h0, 32'h3, 32'h0,
         timer_control_reg(split_timer_pkg::EN_CONT, 0, 0, 0, 0, 0));
      span(0, 1'b1, n);
      check(32'(n), 32'h4);
      // divided internal clock halves the match rate
      wr(`OFF_CLK_DIV, 32'h1);
      rdChk(`OFF_CLK_DIV, 32'h1);
      span(0, 1'b1, n);
      check(32'(n), 32'h8);
      wr(`OFF_CLK_DIV, 32'h0);
      // pulse width and polarity
      for (int inv = 0; inv < 2; inv++) begin
         for (int w = 0; w < 4; w++) begin
            setup(split_timer_pkg::CFG_WIDE, 4'h0, 32'h7, 32'h0,
               timer_control_reg(split_timer_pkg::EN_CONT, 0, w[1:0], inv[0], 0, 0));
            span(2 + inv, 1'b0, n);
            check(32'(n), 32'(w + 1));
         end
      end
      // clock mode halves of equal length
      setup(split_timer_pkg::CFG_WIDE, 4'h0, 32'h3, 32'h0,
         timer_control_reg(split_timer_pkg::EN_CONT, 1, 0, 0, 0, 0));
      span(2, 1'b0, n);
      check(32'(n), 32'h4);
      // clock enable low freezes the output past its next toggle
      ce <= 1'b0;
      repeat (6) @(posedge clk);
      check({31'h0, timerOutputPin}, 32'h0);
      ce <= 1'b1;
      span(3, 1'b0, n);
      check(32'(n), 32'h4);
      doReset();
      setup(split_timer_pkg::CFG_WIDE, 4'h0, 32'h2, 32'h0,
         timer_control_reg(split_timer_pkg::EN_ONCE, 1, 0, 0, 0, 0));
      repeat (12) @(posedge clk);
      check({31'h0, timerOutputPin}, 32'h1);
      rdChk(`OFF_TIMER_CTRL, 32'h00000009);
      // chained: prescaler period 1, upper enable left off
      setup(split_timer_pkg::CFG_CHAINED, 4'h0, 32'h2, 32'h1,
         timer_control_reg(split_timer_pkg::EN_CONT, 0, 0, 0, 0, 0));
      span(0, 1'b1, n);
      check(32'(n), 32'h6);
      // unchained: lower on the pin clock, upper on the internal one
      pinRun <= 1'b1;
      setup(split_timer_pkg::CFG_UNCHAINED, 4'h1, 32'h3, 32'h2,
         timer_control_reg(split_timer_pkg::EN_CONT, 0, 0, 0, 1,
         split_timer_pkg::EN_CONT));
      span(1, 1'b1, n);
      check(32'(n), 32'h6);
      check({31'h0, upperDmaEvent}, 32'h1);
      span(0, 1'b1, n);
      check(32'(n), 32'h20);
      // internal clock gated by the pin level counts half the time
      setup(split_timer_pkg::CFG_WIDE, 4'h0, 32'h3, 32'h0,
         timer_control_reg(split_timer_pkg::EN_CONT, 0, 0, 0, 0, 0) |
         (32'h1 << `TC_GATE_LO));
      span(0, 1'b1, n);
      check(32'(n), 32'h8);
      pinRun <= 1'b0;
      // watchdog locks the configuration until reset
      wr(`OFF_GLOBAL_CTRL, gcr(0, split_timer_pkg::CFG_WATCHDOG, 0));
      wr(`OFF_GLOBAL_CTRL, gcr(0, split_timer_pkg::CFG_WIDE, 0));
      rdChk(`OFF_GLOBAL_CTRL, 32'h00000008);
      doReset();
      rdChk(`OFF_GLOBAL_CTRL, 32'h0);
      conclude();
   end
endmodule // testbench
bind split_timer_top split_timer_monitor mon (.clk, .rst, .ce, .hsel,
   .htrans, .hwrite, .hready, .hreadyout, .hrdata, .hresp, .lowerInterrupt,
   .lowerDmaEvent, .upperInterrupt, .upperDmaEvent);
